// *** logic/global_config_defines.vh ***
// global configuration register constants: offsets, fields, resets, timing
// assumes a 100 MHz core clock; included by bare name
`ifndef GLOBAL_CONFIG_DEFINES_VH
`define GLOBAL_CONFIG_DEFINES_VH

`define GC_REG_ADDR          8'h10
`define GC_BIT_RSVD          7
`define GC_BIT_BIAS_READY    6
`define GC_BIT_LOW_POWER     5
`define GC_BIT_FORCE_ON      4
`define GC_BIT_POWER_KEY_INPUT_STYLE   3
`define GC_BIT_DEBOUNCE      2
`define GC_SRST_HI           1
`define GC_SRST_LO           0
`define GC_RESET_VALUE       8'h00
`define GC_SRST_NONE         2'h0
`define GC_SRST_COLD         2'h1
`define GC_SRST_OFF          2'h2
`define GC_SRST_RSVD         2'h3

// clock rate and times, in their own units
`define GC_CLK_MHZ           100
`define GC_DB_SHORT_US       100
`define GC_DB_LONG_US        30000
`define GC_PD_DELAY_US       60000
`define GC_RST_ASSERT_US     10240
`define GC_SLOT_US           2560
`define GC_SLOT_COUNT        4
`define GC_DISCHARGE_US      125000
`define GC_CYC(us)           ((us) * `GC_CLK_MHZ)

`endif

// *** logic/power_key_input_debounce.v ***
// debouncer for the on-key enable pin with selectable settle time
// assumes the pin is already synchronised to the core clock
`timescale 1ns/10ps
module power_key_input_debounce #(
  parameter SHORT_CYC = 10000,
  parameter LONG_CYC  = 3000000
) (
  input  wire i_core_clk,   // core clock
  input  wire i_rst_b,      // async reset, active low
  input  wire i_pin_sync,   // synchronised pin level
  input  wire i_long_sel,   // 1 selects long settle time
  output reg  o_level       // debounced level
);
  reg [21:0] cnt_q;
  wire [21:0] limit = i_long_sel ? LONG_CYC[21:0] : SHORT_CYC[21:0];

  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_q   <= 22'h000000;
      o_level <= 1'b1;
    end else if (i_pin_sync == o_level) begin
      cnt_q <= 22'h000000;
    end else if (cnt_q >= limit - 22'h000001) begin
      cnt_q   <= 22'h000000;
      o_level <= i_pin_sync;
    end else begin
      cnt_q <= cnt_q + 22'h000001;
    end
  end
endmodule

// *** logic/global_bias_reset_config.v ***
// global bias, on-key and software reset configuration register
// assumes an upstream i2c target delivers decoded byte writes/reads
// Operation
// - register lives at address 0x10 of the i2c target
// - reset loads pattern 00x00x00, x bits from otp defaults
// - bit 7 reserved; host writes zero, read value meaningless
// - bit 6 read-only reports main bias ready
// - bit 5 requests low-power bias mode when one
// - bit 4 forces main bias on; controller may still enable it
// - bit 3 selects push-button or slide-switch on-key style
// - bit 2 selects 100us or 30ms on-key debounce
// - bits 1:0 decode none, cold reset, off; 11 reserved
// - cold reset powers down, resets, powers up again unaided
// - off powers down, resets, waits for a wakeup event
// - other writes take effect right after the acknowledge; writes while a power-down sequence runs are ignored
// - sequence: 60ms, 10.24ms reset, four 2.56ms slots, 125ms discharge
`timescale 1ns/10ps
`include "global_config_defines.vh"
module global_bias_reset_config #(
  parameter PD_DELAY_CYC  = `GC_CYC(`GC_PD_DELAY_US),
  parameter RST_CYC       = `GC_CYC(`GC_RST_ASSERT_US),
  parameter SLOT_CYC      = `GC_CYC(`GC_SLOT_US),
  parameter DISCHARGE_CYC = `GC_CYC(`GC_DISCHARGE_US),
  parameter DB_SHORT_CYC  = `GC_CYC(`GC_DB_SHORT_US),
  parameter DB_LONG_CYC   = `GC_CYC(`GC_DB_LONG_US)
) (
  input  wire       i_core_clk,        // core clock, 100 MHz
  input  wire       i_rst_b,           // async power-on reset, active low
  input  wire       i_otp_low_power,   // otp default for low-power bit
  input  wire       i_otp_debounce,    // otp default for debounce bit
  input  wire [7:0] i_reg_addr,        // register address from i2c target
  input  wire [7:0] i_reg_wdata,       // write byte
  input  wire       i_reg_wr,          // write pulse after acknowledge
  input  wire       i_reg_rd,          // read pulse
  input  wire       i_bias_ok,         // main bias ready, analog side
  input  wire       i_power_key_input_enable_pin,// on-key pin, async
  input  wire       i_wakeup,          // wakeup event, async
  output reg  [7:0] o_reg_rdata,       // read byte
  output reg        o_reg_hit,         // read/write addressed this register
  output reg        o_bias_low_power,  // bias low-power request
  output reg        o_bias_force_on,   // bias forced on
  output reg        o_power_key_input_slide,     // on-key slide-switch style
  output reg        o_power_key_input_level,     // debounced on-key level
  output reg        o_reset_output,    // reset output asserted
  output reg  [3:0] o_slot_off,        // regulator slots powered down
  output reg        o_discharge,       // output discharge active
  output reg        o_powered          // device power enabled
);
  localparam S_RUN   = 3'd0;
  localparam S_DELAY = 3'd1;
  localparam S_RST   = 3'd2;
  localparam S_SLOT  = 3'd3;
  localparam S_DISCH = 3'd4;
  localparam S_OFF   = 3'd5;

  reg        system_reset_condition_q;
  reg        low_power_q;
  reg        force_on_q;
  reg        style_q;
  reg        debounce_q;
  reg [1:0]  cmd_q;
  reg [2:0]  state_q;
  reg [24:0] tmr_q;
  reg [2:0]  slot_q;
  reg        cold_q;
  reg        init_q;
  reg        pin_m_q, pin_s_q, wk_m_q, wk_s_q, bok_m_q, bok_s_q;
  wire       db_level;

  function is_cmd;
    input [1:0] code;
    is_cmd = (code == `GC_SRST_COLD) || (code == `GC_SRST_OFF);
  endfunction

  wire addr_hit = (i_reg_addr == `GC_REG_ADDR);
  wire wr_hit   = i_reg_wr && addr_hit && (state_q == S_RUN) && !system_reset_condition_q;
  wire rd_hit   = i_reg_rd && addr_hit;

  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pin_m_q <= 1'b1;
      pin_s_q <= 1'b1;
      wk_m_q  <= 1'b0;
      wk_s_q  <= 1'b0;
      bok_m_q <= 1'b0;
      bok_s_q <= 1'b0;
    end else begin
      pin_m_q <= i_power_key_input_enable_pin;
      pin_s_q <= pin_m_q;
      wk_m_q  <= i_wakeup;
      wk_s_q  <= wk_m_q;
      bok_m_q <= i_bias_ok;
      bok_s_q <= bok_m_q;
    end
  end

  power_key_input_debounce #(
    .SHORT_CYC (DB_SHORT_CYC),
    .LONG_CYC  (DB_LONG_CYC)
  ) u_debounce (
    .i_core_clk (i_core_clk),
    .i_rst_b    (i_rst_b),
    .i_pin_sync (pin_s_q),
    .i_long_sel (debounce_q),
    .o_level    (db_level)
  );

  // configuration fields; otp strap captured after reset release
  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      init_q      <= 1'b1;
      low_power_q <= 1'b0;
      force_on_q  <= 1'b0;
      style_q     <= 1'b0;
      debounce_q  <= 1'b0;
      cmd_q       <= `GC_SRST_NONE;
    end else if (init_q || system_reset_condition_q) begin
      init_q      <= 1'b0;
      low_power_q <= i_otp_low_power;
      force_on_q  <= 1'b0;
      style_q     <= 1'b0;
      debounce_q  <= i_otp_debounce;
      cmd_q       <= `GC_SRST_NONE;
    end else if (wr_hit) begin
      low_power_q <= i_reg_wdata[`GC_BIT_LOW_POWER];
      force_on_q  <= i_reg_wdata[`GC_BIT_FORCE_ON];
      style_q     <= i_reg_wdata[`GC_BIT_POWER_KEY_INPUT_STYLE];
      debounce_q  <= i_reg_wdata[`GC_BIT_DEBOUNCE];
      cmd_q       <= is_cmd(i_reg_wdata[`GC_SRST_HI:`GC_SRST_LO]) ?
                     i_reg_wdata[`GC_SRST_HI:`GC_SRST_LO] : `GC_SRST_NONE;
    end else if (state_q != S_RUN) begin
      cmd_q <= `GC_SRST_NONE;
    end
  end

  // power-down sequencer
  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q  <= S_RUN;
      tmr_q    <= 25'h0000000;
      slot_q   <= 3'h0;
      cold_q   <= 1'b0;
      system_reset_condition_q <= 1'b0;
    end else begin
      system_reset_condition_q <= 1'b0;
      case (state_q)
        S_RUN: begin
          if (is_cmd(cmd_q)) begin
            state_q <= S_DELAY;
            cold_q  <= (cmd_q == `GC_SRST_COLD);
            tmr_q   <= 25'h0000000;
          end
        end
        S_DELAY: begin
          if (tmr_q == PD_DELAY_CYC[24:0] - 25'h0000001) begin
            state_q <= S_RST;
            tmr_q   <= 25'h0000000;
          end else begin
            tmr_q <= tmr_q + 25'h0000001;
          end
        end
        S_RST: begin
          if (tmr_q == RST_CYC[24:0] - 25'h0000001) begin
            state_q <= S_SLOT;
            slot_q  <= 3'h0;
            tmr_q   <= 25'h0000000;
          end else begin
            tmr_q <= tmr_q + 25'h0000001;
          end
        end
        S_SLOT: begin
          if (tmr_q == SLOT_CYC[24:0] - 25'h0000001) begin
            tmr_q  <= 25'h0000000;
            slot_q <= slot_q + 3'h1;
            if (slot_q == `GC_SLOT_COUNT - 1) begin
              state_q <= S_DISCH;
            end
          end else begin
            tmr_q <= tmr_q + 25'h0000001;
          end
        end
        S_DISCH: begin
          if (tmr_q == DISCHARGE_CYC[24:0] - 25'h0000001) begin
            tmr_q    <= 25'h0000000;
            system_reset_condition_q <= 1'b1;
            state_q  <= cold_q ? S_RUN : S_OFF;
          end else begin
            tmr_q <= tmr_q + 25'h0000001;
          end
        end
        S_OFF: begin
          if (wk_s_q) begin
            state_q <= S_RUN;
          end
        end
        default: state_q <= S_RUN;
      endcase
    end
  end

  // registered outputs and read path
  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_reg_rdata      <= `GC_RESET_VALUE;
      o_reg_hit        <= 1'b0;
      o_bias_low_power <= 1'b0;
      o_bias_force_on  <= 1'b0;
      o_power_key_input_slide    <= 1'b0;
      o_power_key_input_level    <= 1'b1;
      o_reset_output   <= 1'b0;
      o_slot_off       <= 4'h0;
      o_discharge      <= 1'b0;
      o_powered        <= 1'b1;
    end else begin
      o_reg_hit <= (i_reg_wr || i_reg_rd) && addr_hit;
      if (rd_hit) begin
        o_reg_rdata <= {1'b0, bok_s_q, low_power_q, force_on_q,
                        style_q, debounce_q, cmd_q};
      end
      o_bias_low_power <= low_power_q;
      o_bias_force_on  <= force_on_q;
      o_power_key_input_slide    <= style_q;
      o_power_key_input_level    <= db_level;
      o_reset_output   <= (state_q == S_RST) || (state_q == S_SLOT) ||
                          (state_q == S_DISCH) || (state_q == S_OFF);
      o_slot_off       <= (state_q == S_SLOT) ?
                          ((4'h2 << slot_q[1:0]) - 4'h1) :
                          ((state_q == S_DISCH || state_q == S_OFF) ? 4'hF : 4'h0);
      o_discharge      <= (state_q == S_DISCH);
      o_powered        <= (state_q == S_RUN) || (state_q == S_DELAY) ||
                          (state_q == S_RST);
    end
  end
endmodule

// *** sim/global_bias_reset_config_props.sv ***
// checker on the config register ports
// assumes one core clock and shortened counts
`timescale 1ns/10ps
module global_bias_reset_config_props (
  input wire       i_core_clk,
  input wire       i_rst_b,
  input wire [7:0] i_reg_addr,
  input wire [7:0] i_reg_wdata,
  input wire       i_reg_wr,
  input wire       i_reg_rd,
  input wire       i_power_key_input_enable_pin,
  input wire [7:0] o_reg_rdata,
  input wire       o_reg_hit,
  input wire       o_bias_low_power,
  input wire       o_bias_force_on,
  input wire       o_power_key_input_slide,
  input wire       o_power_key_input_level,
  input wire       o_reset_output,
  input wire [3:0] o_slot_off
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  sequence cmd_s;
    i_reg_wr && i_reg_addr == 8'h10 && o_slot_off == 4'h0 && !o_reset_output
      && i_reg_wdata[0] != i_reg_wdata[1];
  endsequence
  sequence plain_s;
    i_reg_wr && i_reg_addr == 8'h10 && o_slot_off == 4'h0 && !o_reset_output
      && i_reg_wdata[0] == i_reg_wdata[1] && $past(i_rst_b, 2);
  endsequence
  addr_miss_a: assert property ((i_reg_wr || i_reg_rd) && i_reg_addr != 8'h10
    |=> !o_reg_hit && $stable(o_reg_rdata)) else $error("foreign hit");
  rsvd_bit_a: assert property (i_reg_rd && i_reg_addr == 8'h10 |=> !o_reg_rdata[7])
    else $error("bit 7 set");
  field_load_a: assert property (plain_s |-> ##2
    {o_bias_low_power, o_bias_force_on, o_power_key_input_slide} == $past(i_reg_wdata[5:3], 2))
    else $error("field not loaded");
  rsvd_code_a: assert property (plain_s ##0 i_reg_wdata[0] |=> ##8 !o_reset_output [*8])
    else $error("code 3 acted");
  seq_start_a: assert property (cmd_s |=> !o_reset_output [*6] ##[1:40] o_reset_output)
    else $error("bad start");
  slot_order_a: assert property ($rose(o_slot_off[0]) |-> o_reset_output
    && o_slot_off == 4'h1 ##[1:20] o_slot_off == 4'h3) else $error("bad slots");
  debounce_a: assert property ($changed(o_power_key_input_level)
    |-> o_power_key_input_level == $past(i_power_key_input_enable_pin, 5)) else $error("short debounce");
endmodule
bind global_bias_reset_config global_bias_reset_config_props u_props (.i_core_clk, .i_rst_b,
  .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .i_power_key_input_enable_pin, .o_reg_rdata,
  .o_reg_hit, .o_bias_low_power, .o_bias_force_on, .o_power_key_input_slide, .o_power_key_input_level,
  .o_reset_output, .o_slot_off);

// *** sim/host_model.sv ***
// host model: single-byte register accesses as one-cycle pulses
// assumes the register port samples on the rising clock edge
`timescale 1ns/10ps
module host_model (
  input  wire       i_core_clk,        // core clock
  output reg  [7:0] o_addr = 8'h00,    // address
  output reg  [7:0] o_wdata = 8'h00,   // write byte
  output reg        o_wr = 1'b0,       // write pulse
  output reg        o_rd = 1'b0        // read pulse
);
  task access(input wr, input [7:0] a, input [7:0] d);
    begin
      @(posedge i_core_clk);
      o_addr  <= a;
      o_wdata <= d & 8'h7F;
      o_wr    <= wr;
      o_rd    <= !wr;
      @(posedge i_core_clk);
      o_wr    <= 1'b0;
      o_rd    <= 1'b0;
      o_addr  <= ~a;
      o_wdata <= ~d;
    end
  endtask
  // settle and post-command gaps
  task pause(input integer n);
    repeat (n) @(posedge i_core_clk);
  endtask
endmodule

// *** sim/global_bias_reset_config_bench.sv ***
// self-checking bench for the config register
// assumes shortened counts; host model drives the register port
`timescale 1ns/10ps
module global_bias_reset_config_bench;
  reg        i_core_clk, i_rst_b, i_otp_low_power, i_otp_debounce;
  reg        i_bias_ok, i_power_key_input_enable_pin, i_wakeup;
  wire [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata;
  wire [3:0] o_slot_off;
  wire       i_reg_wr, i_reg_rd, o_reg_hit, o_bias_low_power, o_bias_force_on;
  wire       o_power_key_input_slide, o_power_key_input_level, o_reset_output, o_discharge, o_powered;
  integer    n_fail = 0, tests_run = 0, i;
  global_bias_reset_config #(.PD_DELAY_CYC(8), .RST_CYC(6), .SLOT_CYC(4),
    .DISCHARGE_CYC(10), .DB_LONG_CYC(20)) u_global_bias_reset_config (
    .i_core_clk, .i_rst_b, .i_otp_low_power, .i_otp_debounce, .i_reg_addr, .i_reg_wdata,
    .i_reg_wr, .i_reg_rd, .i_bias_ok, .i_power_key_input_enable_pin, .i_wakeup, .o_reg_rdata,
    .o_reg_hit, .o_bias_low_power, .o_bias_force_on, .o_power_key_input_slide, .o_power_key_input_level,
    .o_reset_output, .o_slot_off, .o_discharge, .o_powered);
  host_model u_host_model (.i_core_clk, .o_addr(i_reg_addr), .o_wdata(i_reg_wdata),
    .o_wr(i_reg_wr), .o_rd(i_reg_rd));
  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end
  task check(input [7:0] seen, input [7:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("mismatch %0t: %h not %h", $time, seen, exp);
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d fails %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  task rd(input [7:0] exp);
    begin
      u_host_model.access(1'b0, 8'h10, 8'h00);
      #1;
      check(o_reg_hit, 1'b1);
      check(o_reg_rdata, exp);
    end
  endtask
  task t_fields;
    begin
      u_host_model.access(1'b1, 8'h10, 8'h9C);
      i_bias_ok <= 1'b0;
      u_host_model.pause(20);
      rd(8'h1C);
      check({o_bias_low_power, o_bias_force_on, o_power_key_input_slide}, 8'h03);
      u_host_model.access(1'b1, 8'h10, 8'h23);
      i_bias_ok <= 1'b1;
      u_host_model.pause(20);
      rd(8'h60);
      check(o_reset_output, 1'b0);
      u_host_model.access(1'b0, 8'h11, 8'h00);
      #1;
      check(o_reg_hit, 1'b0);
      $display("fields done");
    end
  endtask
  task t_debounce;
    begin
      @(posedge i_core_clk);
      i_power_key_input_enable_pin <= 1'b0;
      repeat (9990) @(negedge i_core_clk);
      check(o_power_key_input_level, 1'b1);
      repeat (30) @(negedge i_core_clk);
      check(o_power_key_input_level, 1'b0);
      u_host_model.access(1'b1, 8'h10, 8'h24);
      i_power_key_input_enable_pin <= 1'b1;
      repeat (12) @(negedge i_core_clk);
      check(o_power_key_input_level, 1'b0);
      repeat (20) @(negedge i_core_clk);
      check(o_power_key_input_level, 1'b1);
      $display("debounce done");
    end
  endtask
  task t_cmd(input [1:0] code, input otp, input [7:0] exp);
    begin
      u_host_model.access(1'b1, 8'h10, {6'h02, code});
      i_otp_debounce <= otp;
      i_otp_low_power <= !otp;
      u_host_model.pause(36);
      #1;
      check({o_discharge, o_reset_output, o_powered}, 8'h06);
      check(o_slot_off, 4'hF);
      u_host_model.pause(24);
      #1;
      check(o_powered, code == 2'h1);
      check(o_reset_output, code == 2'h2);
      check(o_slot_off, code == 2'h1 ? 4'h0 : 4'hF);
      if (code == 2'h2) begin
        @(posedge i_core_clk);
        i_wakeup <= 1'b1;
        for (i = 0; i < 50 && o_powered !== 1'b1; i = i + 1)
          @(posedge i_core_clk);
        i_wakeup <= 1'b0;
      end
      check(o_powered, 1'b1);
      if (o_powered !== 1'b1)
        tally_and_finish;
      check(o_reset_output, 1'b0);
      u_host_model.pause(20);
      rd(exp);
      $display("command done");
    end
  endtask
  task t_reset(input lp, input db);
    begin
      u_host_model.access(1'b1, 8'h10, 8'h0A);
      u_host_model.pause(25);
      #1;
      check(o_reset_output, 1'b1);
      @(posedge i_core_clk);
      i_rst_b <= 1'b0;
      i_otp_low_power <= lp;
      i_otp_debounce <= db;
      repeat (2) @(posedge i_core_clk);
      #1;
      check({o_powered, o_reset_output, o_slot_off}, 8'h20);
      check(o_reg_rdata, 8'h00);
      @(posedge i_core_clk);
      i_rst_b <= 1'b1;
      u_host_model.pause(3);
      rd({2'b01, lp, 2'b00, db, 2'b00});
      check({o_bias_low_power, o_power_key_input_slide}, {6'h00, lp, 1'b0});
      $display("reset test done");
    end
  endtask
  initial begin
    i_rst_b = 1'b0;
    i_otp_low_power = 1'b1;
    i_otp_debounce = 1'b0;
    i_bias_ok = 1'b1;
    i_power_key_input_enable_pin = 1'b1;
    i_wakeup = 1'b0;
    repeat (5) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    u_host_model.pause(3);
    rd(8'h60);
    $display("reset done");
    t_fields;
    t_debounce;
    t_cmd(2'h1, 1'b0, 8'h60);
    t_cmd(2'h2, 1'b1, 8'h44);
    t_reset(1'b0, 1'b0);
    tally_and_finish;
  end
endmodule
